//--- slcs_chk.sv
module slcs_chk #(
	parameter int PIX_W  = slcs_pkg::PIX_W,
	parameter int LINE_W = slcs_pkg::LINE_W
) (
	// clock and reset
	input wire logic              ref_clk,
	input wire logic              arst_n,
	// host side
	input wire logic              host_line_ready_n,
	input wire logic              irq_clear_cmd,
	input wire logic              correction_bypass,
	input wire logic [LINE_W-1:0] line_count_preset,
	// pixel stream in
	input wire logic              pix_valid,
	input wire logic [PIX_W-1:0]  pix_data,
	// line status and output
	input wire logic              line_cycle_strobe,
	input wire logic              sensor_start_pulse,
	input wire logic              roller_step_pulse_n,
	input wire logic              start_flag,
	input wire logic              line_active_flag,
	input wire logic              irq,
	input wire logic              bit_output_window_n,
	input wire logic              out_valid,
	input wire logic [PIX_W-1:0]  out_pix,
	input wire logic              bit_out_video
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic        strb_q;
	logic        seen_q;
	logic [20:0] per_q;
	wire         rise = line_cycle_strobe & ~strb_q;
	// first rise after reset has no full period behind it, so it is skipped
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			strb_q <= 1'b0;
			seen_q <= 1'b0;
			per_q  <= 21'h000000;
		end else begin
			strb_q <= line_cycle_strobe;
			seen_q <= seen_q | rise;
			per_q  <= rise ? 21'h000001 : per_q + 21'h000001;
		end
	end
	line_len_a: assert property (rise && seen_q |-> per_q == (21'(line_count_preset) + 21'h1) * 21'h10)
		else $error("line period wrong");
	line_begin_a: assert property ($rose(line_active_flag) |-> $past(start_flag) && !$past(host_line_ready_n) && sensor_start_pulse)
		else $error("line began without its conditions");
	roller_a: assert property ($fell(roller_step_pulse_n) |-> $rose(line_active_flag))
		else $error("roller step outside line begin");
	line_end_a: assert property ($fell(line_active_flag) |-> $past(host_line_ready_n) && $rose(line_cycle_strobe))
		else $error("line ended without strobe rise and ready high");
	irq_set_a: assert property ($fell(line_active_flag) |-> irq)
		else $error("interrupt missing at line end");
	irq_hold_a: assert property (irq && !irq_clear_cmd |=> irq)
		else $error("interrupt dropped without clear");
	irq_clear_a: assert property ($fell(irq) |-> $past(irq_clear_cmd))
		else $error("interrupt fell without clear");
	window_a: assert property (!bit_output_window_n |-> line_active_flag || $past(line_active_flag))
		else $error("window open outside line");
	// a pixel leaves one edge after the open window, its copy two edges after
	out_win_a: assert property (out_valid |-> !$past(bit_output_window_n) || !$past(bit_output_window_n, 2))
		else $error("pixel out while window closed");
	video_a: assert property (out_valid |-> bit_out_video == out_pix[PIX_W-1])
		else $error("video bit differs from pixel msb");
	bypass_a: assert property (out_valid && $past(pix_valid, 2) && $past(correction_bypass, 2) |-> out_pix == $past(pix_data, 2))
		else $error("bypassed pixel altered");
	cover property ($fell(line_active_flag));
	cover property (out_valid && correction_bypass);
	cover property ($fell(roller_step_pulse_n));
endmodule : slcs_chk

bind slcs_top slcs_chk #(.PIX_W(PIX_W), .LINE_W(LINE_W)) chk_i (.ref_clk(ref_clk), .arst_n(arst_n),
	.host_line_ready_n(host_line_ready_n), .irq_clear_cmd(irq_clear_cmd), .correction_bypass(correction_bypass),
	.line_count_preset(line_count_preset), .pix_valid(pix_valid), .pix_data(pix_data),
	.line_cycle_strobe(line_cycle_strobe), .sensor_start_pulse(sensor_start_pulse),
	.roller_step_pulse_n(roller_step_pulse_n), .start_flag(start_flag), .line_active_flag(line_active_flag),
	.irq(irq), .bit_output_window_n(bit_output_window_n), .out_valid(out_valid), .out_pix(out_pix),
	.bit_out_video(bit_out_video));

//--- slcs_corr_mem.sv
module slcs_corr_mem #(
	parameter int DEPTH = slcs_pkg::CORR_DEPTH
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic arst_n,
	// access port
	slcs_mem_if.mem   mp
);
	logic [slcs_pkg::CORR_W-1:0] store [DEPTH];
	logic [slcs_pkg::CORR_W-1:0] rdata_q;

	// array is not reset: contents are only meaningful after a capture
	always_ff @(posedge ref_clk) begin
		if (mp.we) begin
			store[mp.waddr] <= mp.wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= '0;
		end else if (mp.re) begin
			rdata_q <= store[mp.raddr];
		end
	end

	assign mp.rdata = rdata_q;
endmodule : slcs_corr_mem

//--- slcs_mem_if.sv
interface slcs_mem_if;
	logic                           we;
	logic [slcs_pkg::CORR_AW-1:0]   waddr;
	logic [slcs_pkg::CORR_W-1:0]    wdata;
	logic                           re;
	logic [slcs_pkg::CORR_AW-1:0]   raddr;
	logic [slcs_pkg::CORR_W-1:0]    rdata;
	modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
	modport mem  (input we, waddr, wdata, re, raddr, output rdata);
endinterface : slcs_mem_if

//--- slcs_pkg.sv
package slcs_pkg;
	// timing
	localparam int          PIX_DIV         = 16;
	localparam int          AGC_RAISE_LINES = 8;
	localparam int          AGC_LOWER_LINES = 8;
	localparam int          CAPTURE_LINES   = 8;
	// storage shapes
	localparam int          CORR_DEPTH      = 1024;
	localparam int          CORR_AW         = 10;
	localparam int          CORR_W          = 6;
	localparam int          HPAT_LEN        = 100;
	localparam int          HPAT_PW         = 7;
	localparam int          PIX_W           = 6;
	localparam int          LINE_W          = 16;
	// correction arithmetic: gain = GAIN_NUM / white, stored as gain - GAIN_BASE
	localparam logic [11:0] GAIN_NUM        = 12'hFC0;
	localparam logic [6:0]  GAIN_BASE       = 7'h40;
	localparam logic [5:0]  WHITE_MIN       = 6'h20;
	localparam logic [5:0]  PIX_MAX         = 6'h3F;
	localparam int          GAIN_SHIFT      = 6;
	// reset values
	localparam logic [5:0]  BLACK_RST       = 6'h00;
	localparam logic [99:0] HPAT_RST        = '0;
endpackage : slcs_pkg

//--- slcs_sensor_model.sv
module slcs_sensor_model #(
	parameter int NPIX = 16,
	parameter int GAP  = 4
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	// line start and scene
	input  wire logic       sensor_start_pulse,
	input  wire logic [5:0] level,
	input  wire logic       ovf_en,
	// converter stream
	output logic            pix_valid,
	output logic [5:0]      pix_data,
	output logic            adc_overflow
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// between pixels the data lines show the inverse level, never a stale copy
	always @(negedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt = NPIX * GAP;
			pix_valid <= 1'b0;
			pix_data  <= ~level;
		end else begin
			if (sensor_start_pulse) begin
				cnt = 0;
			end else if (cnt < NPIX * GAP) begin
				cnt++;
			end
			pix_valid <= (cnt < NPIX * GAP) && (cnt % GAP == 0);
			pix_data  <= ((cnt < NPIX * GAP) && (cnt % GAP == 0)) ? level : ~level;
		end
	end
	assign adc_overflow = ovf_en;
endmodule : slcs_sensor_model

//--- slcs_top.sv
// Operation
// - gain command: raise gain for 8 lines
// - then 8 lines lowering gain on overflow
// - capture: per two-pixel block, store 6-bit value
// - scan: read block value, correct every pixel
// - bypass bit passes pixels uncorrected
// - four-pixel block select widens blocks
// - correction exact only within 50% span
// - 100 single-bit writes load horizontal pattern
// - pattern 0 one pixel; 1 drop or double
// - reduction: bit 1 suppresses current line
// - enlargement: bit steers roller for next line
// - strobe fall takes scan, sets start flag
// - start pulse with ready low begins line, roller
// - data only while window low; dropped lines high
// - strobe rise with ready high ends line
// - line-active fall raises interrupt
// - capture command generates data over 8 lines
// - line lasts (preset+1) times 16 clocks
module slcs_top #(
	parameter int PIX_W    = slcs_pkg::PIX_W,
	parameter int LINE_W   = slcs_pkg::LINE_W,
	parameter int HPAT_LEN = slcs_pkg::HPAT_LEN
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// commands and configuration
	input  wire logic              gain_peak_cmd,
	input  wire logic              shading_capture_mode,
	input  wire logic              scan_cmd,
	input  wire logic              imager_type_sel,
	input  wire logic              capture_polarity_sel,
	input  wire logic              dual_correction_sel,
	input  wire logic              correction_bypass,
	input  wire logic              four_pixel_block_sel,
	input  wire logic              scale_enlarge,
	input  wire logic              scale_axis_sel,
	input  wire logic              scale_pattern_bit,
	input  wire logic              scale_pattern_wr,
	input  wire logic              scale_ptr_rst,
	input  wire logic              irq_clear_cmd,
	input  wire logic              host_line_ready_n,
	input  wire logic [LINE_W-1:0] line_count_preset,
	input  wire logic [LINE_W-1:0] start_pulse_pos,
	// converter stream
	input  wire logic              pix_valid,
	input  wire logic [PIX_W-1:0]  pix_data,
	input  wire logic              adc_overflow,
	// line timing and sensor
	output logic                   line_cycle_strobe,
	output logic                   sensor_start_pulse,
	output logic                   roller_step_pulse_n,
	// gain control
	output logic                   gain_up_pulse,
	output logic                   gain_down_pulse,
	output logic                   gain_peak_done,
	// capture status
	output logic                   capture_done,
	output logic [PIX_W-1:0]       black_level,
	// line status and output
	output logic                   start_flag,
	output logic                   line_active_flag,
	output logic                   irq,
	output logic                   bit_output_window_n,
	output logic                   out_valid,
	output logic [PIX_W-1:0]       out_pix,
	output logic                   bit_out_video
);
	typedef enum logic [1:0] {AGC_IDLE, AGC_RAISE, AGC_LOWER, AGC_DONE} slcs_agc_e;

	function automatic logic [slcs_pkg::CORR_AW-1:0] blk_addr(input logic [11:0] idx, input logic four);
		blk_addr = four ? idx[11:2] : idx[10:1];
	endfunction : blk_addr

	// white below half of full scale is clamped: correction is not exact there
	function automatic logic [5:0] gain_code(input logic [5:0] white);
		logic [5:0]  w;
		logic [11:0] g;
		w = (white < slcs_pkg::WHITE_MIN) ? slcs_pkg::WHITE_MIN : white;
		g = slcs_pkg::GAIN_NUM / {6'h00, w};
		gain_code = 6'(g - {5'h00, slcs_pkg::GAIN_BASE});
	endfunction : gain_code

	slcs_mem_if mif ();
	slcs_corr_mem u_mem (.ref_clk(ref_clk), .arst_n(arst_n), .mp(mif.mem));

	// line timing
	logic [3:0]        div_q;
	logic [LINE_W-1:0] cnt_q;
	logic              pix_tick, line_tick, half_tick, sh_tick;

	assign pix_tick  = (div_q == 4'(slcs_pkg::PIX_DIV - 1));
	assign line_tick = pix_tick && (cnt_q == '0);
	assign half_tick = pix_tick && (cnt_q == (line_count_preset >> 1));
	assign sh_tick   = pix_tick && (cnt_q == start_pulse_pos);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= '0;
		end else begin
			div_q <= pix_tick ? 4'h0 : div_q + 4'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else if (pix_tick) begin
			cnt_q <= (cnt_q == '0) ? line_count_preset : cnt_q - 1'b1;
		end
	end

	// strobe rises at reload and falls half way through the line
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			line_cycle_strobe  <= 1'b0;
			sensor_start_pulse <= 1'b0;
		end else begin
			sensor_start_pulse <= sh_tick;
			if (line_tick) begin
				line_cycle_strobe <= 1'b1;
			end else if (half_tick) begin
				line_cycle_strobe <= 1'b0;
			end
		end
	end

	// line sequencing
	logic line_begin, line_end, line_on_q, vbit_q, drop_q, hold_q;

	assign line_begin = sh_tick && start_flag && !host_line_ready_n && !line_active_flag;
	assign line_end   = line_tick && host_line_ready_n && line_active_flag;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			start_flag <= 1'b0;
		end else if (half_tick) begin
			start_flag <= scan_cmd;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			line_active_flag <= 1'b0;
		end else if (line_begin) begin
			line_active_flag <= 1'b1;
		end else if (line_end) begin
			line_active_flag <= 1'b0;
		end
	end

	// the fall of line_active_flag is line_end; a fresh fall beats a clear
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else if (line_end) begin
			irq <= 1'b1;
		end else if (irq_clear_cmd) begin
			irq <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			vbit_q <= 1'b0;
		end else if (scale_pattern_wr && scale_axis_sel) begin
			vbit_q <= scale_pattern_bit;
		end
	end

	// reduction acts on this line, enlargement on the roller for the next
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			drop_q <= 1'b0;
			hold_q <= 1'b0;
		end else if (line_begin) begin
			drop_q <= !scale_enlarge && vbit_q;
			hold_q <= scale_enlarge && vbit_q;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			roller_step_pulse_n <= 1'b1;
		end else begin
			roller_step_pulse_n <= !(line_begin && !hold_q);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_output_window_n <= 1'b1;
		end else begin
			bit_output_window_n <= !(line_active_flag && !drop_q);
		end
	end

	// sensor window for gain and capture work, from start pulse to reload
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			line_on_q <= 1'b0;
		end else if (sh_tick) begin
			line_on_q <= 1'b1;
		end else if (line_tick) begin
			line_on_q <= 1'b0;
		end
	end

	// peak detection sequencer
	slcs_agc_e agc_q;
	logic [3:0] agc_lines_q;
	logic       gain_cmd_q, ovf_seen_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			agc_q         <= AGC_IDLE;
			agc_lines_q   <= '0;
			gain_cmd_q    <= 1'b0;
			ovf_seen_q    <= 1'b0;
			gain_up_pulse <= 1'b0;
			gain_down_pulse <= 1'b0;
		end else begin
			gain_cmd_q      <= gain_peak_cmd;
			gain_up_pulse   <= 1'b0;
			gain_down_pulse <= 1'b0;
			if (line_tick) begin
				ovf_seen_q <= 1'b0;
			end else if (adc_overflow && line_on_q) begin
				ovf_seen_q <= 1'b1;
			end
			if (!gain_peak_cmd) begin
				agc_q <= AGC_IDLE;
			end else begin
				unique case (agc_q)
					AGC_IDLE: begin
						if (!gain_cmd_q) begin
							agc_q       <= AGC_RAISE;
							agc_lines_q <= '0;
						end
					end
					AGC_RAISE: begin
						if (line_tick) begin
							gain_up_pulse <= 1'b1;
							agc_lines_q   <= agc_lines_q + 4'h1;
							if (agc_lines_q == 4'(slcs_pkg::AGC_RAISE_LINES - 1)) begin
								agc_q       <= AGC_LOWER;
								agc_lines_q <= '0;
							end
						end
					end
					AGC_LOWER: begin
						if (line_tick) begin
							gain_down_pulse <= ovf_seen_q || adc_overflow;
							agc_lines_q     <= agc_lines_q + 4'h1;
							if (agc_lines_q == 4'(slcs_pkg::AGC_LOWER_LINES - 1)) begin
								agc_q <= AGC_DONE;
							end
						end
					end
					AGC_DONE: begin
						agc_q <= AGC_DONE;
					end
				endcase
			end
		end
	end

	assign gain_peak_done = (agc_q == AGC_DONE);

	// shading capture: block averages over the last capture line stand
	logic [3:0]  cap_lines_q;
	logic        cap_cmd_q, cap_busy, cap_wr, blk_last;
	logic [11:0] pix_idx_q;
	logic [7:0]  blk_sum_q, blk_sum_d;
	logic [5:0]  blk_avg;

	assign cap_busy  = shading_capture_mode && (cap_lines_q < 4'(slcs_pkg::CAPTURE_LINES));
	assign blk_last  = four_pixel_block_sel ? (pix_idx_q[1:0] == 2'b11) : pix_idx_q[0];
	assign blk_sum_d = blk_sum_q + {2'b00, pix_data};
	assign blk_avg   = four_pixel_block_sel ? blk_sum_d[7:2] : blk_sum_d[6:1];
	assign cap_wr    = cap_busy && line_on_q && pix_valid && blk_last;
	assign capture_done = shading_capture_mode && !cap_busy;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_cmd_q   <= 1'b0;
			cap_lines_q <= '0;
		end else begin
			cap_cmd_q <= shading_capture_mode;
			if (shading_capture_mode && !cap_cmd_q) begin
				cap_lines_q <= '0;
			end else if (cap_busy && line_tick) begin
				cap_lines_q <= cap_lines_q + 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pix_idx_q <= '0;
			blk_sum_q <= '0;
		end else if (sh_tick) begin
			pix_idx_q <= '0;
			blk_sum_q <= '0;
		end else if (pix_valid) begin
			pix_idx_q <= pix_idx_q + 12'h001;
			blk_sum_q <= blk_last ? 8'h00 : blk_sum_d;
		end
	end

	// black pass keeps the darkest-correcting level as one global offset
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			black_level <= slcs_pkg::BLACK_RST;
		end else if (cap_wr && dual_correction_sel && !capture_polarity_sel) begin
			if (blk_avg > black_level) begin
				black_level <= blk_avg;
			end
		end
	end

	logic [5:0] white_rel;
	assign white_rel = dual_correction_sel ? blk_avg - black_level : blk_avg;
	assign mif.we    = cap_wr && capture_polarity_sel;
	assign mif.waddr = blk_addr(pix_idx_q, four_pixel_block_sel);
	assign mif.wdata = gain_code(white_rel);

	// scan path: read gain of the block, correct one stage later
	logic       scan_pix;
	logic       p1_v_q, p1_h_q, dup_q;
	logic [5:0] p1_q, corr, diff;
	logic [12:0] prod;

	assign scan_pix  = pix_valid && line_active_flag && !cap_busy;
	assign mif.re    = scan_pix;
	assign mif.raddr = blk_addr(pix_idx_q, four_pixel_block_sel);
	assign diff      = (dual_correction_sel && p1_q > black_level) ? p1_q - black_level :
	                   (dual_correction_sel ? 6'h00 : p1_q);
	assign prod      = diff * ({1'b0, mif.rdata} + slcs_pkg::GAIN_BASE);
	assign corr      = correction_bypass ? p1_q :
	                   ((prod >> slcs_pkg::GAIN_SHIFT) > 13'(slcs_pkg::PIX_MAX)) ? slcs_pkg::PIX_MAX :
	                   prod[11:6];

	// horizontal pattern, one bit per write, pointer steps per pixel
	logic [HPAT_LEN-1:0] hpat_q;
	logic [6:0]          hwr_q, hrd_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hpat_q <= slcs_pkg::HPAT_RST;
			hwr_q  <= '0;
		end else if (scale_ptr_rst) begin
			hwr_q <= '0;
		end else if (scale_pattern_wr && !scale_axis_sel) begin
			hpat_q[hwr_q] <= scale_pattern_bit;
			hwr_q <= (hwr_q == 7'(HPAT_LEN - 1)) ? 7'h00 : hwr_q + 7'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hrd_q <= '0;
		end else if (sh_tick) begin
			hrd_q <= '0;
		end else if (scan_pix) begin
			hrd_q <= (hrd_q == 7'(HPAT_LEN - 1)) ? 7'h00 : hrd_q + 7'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			p1_v_q <= 1'b0;
			p1_h_q <= 1'b0;
			p1_q   <= '0;
		end else begin
			p1_v_q <= scan_pix;
			if (scan_pix) begin
				p1_q   <= pix_data;
				p1_h_q <= hpat_q[hrd_q];
			end
		end
	end

	// pixels arrive no closer than 4 clocks apart, so the doubled copy never collides
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_valid     <= 1'b0;
			out_pix       <= '0;
			bit_out_video <= 1'b0;
			dup_q         <= 1'b0;
		end else begin
			out_valid <= 1'b0;
			dup_q     <= 1'b0;
			if (p1_v_q && !bit_output_window_n && !(p1_h_q && !scale_enlarge)) begin
				out_valid     <= 1'b1;
				out_pix       <= corr;
				bit_out_video <= corr[5];
				dup_q         <= p1_h_q && scale_enlarge;
			end else if (dup_q) begin
				out_valid <= 1'b1;
			end
		end
	end
endmodule : slcs_top

//--- tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// 48 white gives gain 84/64, so level 40 becomes 52
	localparam logic [5:0] WHITE = 6'h30;
	localparam logic [5:0] PIXL  = 6'h28;
	localparam logic [5:0] CORR  = 6'h34;
	// black 4 under white 48 leaves a span of 44: gain 91/64, so level 40 becomes 51
	localparam logic [5:0] BLACK = 6'h04;
	localparam logic [5:0] CORR2 = 6'h33;
	localparam int         LINE  = 256;
	logic        ref_clk = 1'b0, arst_n = 1'b0, gain_peak_cmd = 1'b0, shading_capture_mode = 1'b0, scan_cmd = 1'b0;
	logic        imager_type_sel = 1'b0, capture_polarity_sel = 1'b0, dual_correction_sel = 1'b0;
	logic        correction_bypass = 1'b0, four_pixel_block_sel = 1'b0, scale_enlarge = 1'b0, scale_axis_sel = 1'b0;
	logic        scale_pattern_bit = 1'b0, scale_pattern_wr = 1'b0, scale_ptr_rst = 1'b0, irq_clear_cmd = 1'b0;
	logic        host_line_ready_n = 1'b1, ovf_en = 1'b0;
	logic [15:0] line_count_preset = 16'h000F, start_pulse_pos = 16'h0006;
	logic [5:0]  level = WHITE, pix_data, out_pix, black_level, last_pix;
	logic        pix_valid, adc_overflow, line_cycle_strobe, sensor_start_pulse, roller_step_pulse_n;
	logic        gain_up_pulse, gain_down_pulse, gain_peak_done, capture_done, start_flag, line_active_flag;
	logic        irq, bit_output_window_n, out_valid, bit_out_video;
	int          fails = 0, total_checks = 0, cyc = 0, n_out = 0, n_roll = 0, n_up = 0, n_dn = 0, i;

	slcs_top uut (.ref_clk(ref_clk), .arst_n(arst_n), .gain_peak_cmd(gain_peak_cmd),
		.shading_capture_mode(shading_capture_mode), .scan_cmd(scan_cmd), .imager_type_sel(imager_type_sel),
		.capture_polarity_sel(capture_polarity_sel), .dual_correction_sel(dual_correction_sel),
		.correction_bypass(correction_bypass), .four_pixel_block_sel(four_pixel_block_sel),
		.scale_enlarge(scale_enlarge), .scale_axis_sel(scale_axis_sel), .scale_pattern_bit(scale_pattern_bit),
		.scale_pattern_wr(scale_pattern_wr), .scale_ptr_rst(scale_ptr_rst), .irq_clear_cmd(irq_clear_cmd),
		.host_line_ready_n(host_line_ready_n), .line_count_preset(line_count_preset),
		.start_pulse_pos(start_pulse_pos), .pix_valid(pix_valid), .pix_data(pix_data), .adc_overflow(adc_overflow),
		.line_cycle_strobe(line_cycle_strobe), .sensor_start_pulse(sensor_start_pulse),
		.roller_step_pulse_n(roller_step_pulse_n), .gain_up_pulse(gain_up_pulse), .gain_down_pulse(gain_down_pulse),
		.gain_peak_done(gain_peak_done), .capture_done(capture_done), .black_level(black_level),
		.start_flag(start_flag), .line_active_flag(line_active_flag), .irq(irq),
		.bit_output_window_n(bit_output_window_n), .out_valid(out_valid), .out_pix(out_pix),
		.bit_out_video(bit_out_video));
	slcs_sensor_model sensor (.ref_clk(ref_clk), .arst_n(arst_n), .sensor_start_pulse(sensor_start_pulse),
		.level(level), .ovf_en(ovf_en), .pix_valid(pix_valid), .pix_data(pix_data), .adc_overflow(adc_overflow));

	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (out_valid === 1'b1) begin
			n_out++;
			last_pix = out_pix;
		end
		if (roller_step_pulse_n === 1'b0) n_roll++;
		if (gain_up_pulse === 1'b1) n_up++;
		if (gain_down_pulse === 1'b1) n_dn++;
		if (cyc == 25000) begin
			fails++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [5:0] exp, input logic [5:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	task automatic chkn(input string nm, input int exp, input int got);
		total_checks++;
		if (got != exp) begin
			fails++;
			$display("BAD %s expected %0d seen %0d", nm, exp, got);
		end
	endtask : chkn
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	task automatic wr_scale(input logic axis, input logic b);
		scale_axis_sel    = axis;
		scale_pattern_bit = b;
		scale_pattern_wr  = 1'b1;
		tick(1);
		scale_pattern_wr  = 1'b0;
		tick(1);
	endtask : wr_scale
	// host side of one line: vertical bit, clear, ready low, then ready high to close
	task automatic run_line(input logic vb, input int e_out, input int e_roll);
		wr_scale(1'b1, vb);
		irq_clear_cmd = 1'b1;
		tick(1);
		irq_clear_cmd = 1'b0;
		tick(1);
		chk("irq cleared", 6'h00, irq);
		n_out  = 0;
		n_roll = 0;
		host_line_ready_n = 1'b0;
		for (i = 0; i < 600 && line_active_flag !== 1'b1; i++) tick(1);
		tick(80);
		host_line_ready_n = 1'b1;
		for (i = 0; i < 300 && irq !== 1'b1; i++) tick(1);
		chk("irq at line end", 6'h01, irq);
		chkn("pixels out", e_out, n_out);
		chkn("roller steps", e_roll, n_roll);
	endtask : run_line
	task automatic finish_test();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		arst_n = 1'b1;
		chk("irq reset", 6'h00, irq);
		chk("window reset", 6'h01, bit_output_window_n);
		chk("roller reset", 6'h01, roller_step_pulse_n);
		chk("black reset", 6'h00, black_level);
		ovf_en        = 1'b1;
		gain_peak_cmd = 1'b1;
		tick(20 * LINE);
		chkn("gain raise lines", 8, n_up);
		chkn("gain lower lines", 8, n_dn);
		chk("gain done", 6'h01, gain_peak_done);
		gain_peak_cmd = 1'b0;
		ovf_en        = 1'b0;
		capture_polarity_sel = 1'b1;
		shading_capture_mode = 1'b1;
		tick(10 * LINE);
		chk("capture done", 6'h01, capture_done);
		shading_capture_mode = 1'b0;
		scale_ptr_rst = 1'b1;
		tick(1);
		scale_ptr_rst = 1'b0;
		for (int k = 0; k < 100; k++) wr_scale(1'b0, k == 1 || k == 5);
		level    = PIXL;
		scan_cmd = 1'b1;
		run_line(1'b0, 14, 1);
		chk("corrected pixel", CORR, last_pix);
		run_line(1'b1, 0, 1);
		correction_bypass = 1'b1;
		run_line(1'b0, 14, 1);
		chk("bypassed pixel", PIXL, last_pix);
		correction_bypass    = 1'b0;
		scale_enlarge        = 1'b1;
		four_pixel_block_sel = 1'b1;
		run_line(1'b1, 18, 1);
		chk("four pixel blocks", CORR, last_pix);
		run_line(1'b0, 18, 0);
		run_line(1'b0, 18, 1);
		// black pass first, so the white pass is measured above the black offset
		imager_type_sel      = 1'b1;
		dual_correction_sel  = 1'b1;
		capture_polarity_sel = 1'b0;
		level                = BLACK;
		shading_capture_mode = 1'b1;
		tick(10 * LINE);
		chk("black level", BLACK, black_level);
		shading_capture_mode = 1'b0;
		tick(1);
		capture_polarity_sel = 1'b1;
		level                = WHITE;
		shading_capture_mode = 1'b1;
		tick(10 * LINE);
		chk("white after black", 6'h01, capture_done);
		shading_capture_mode = 1'b0;
		level = PIXL;
		run_line(1'b0, 18, 1);
		chk("dual corrected pixel", CORR2, last_pix);
		finish_test();
	end
endmodule : tb_top
